// >>> sel_pkg.sv
// package of constants and types for the serial eeprom boot loader
`default_nettype none
package sel_pkg;
  // clock and i2c timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int TICK_W = 16;
  // eeprom addressing
  localparam logic [6:0] EE_DEV_ADDR = 7'h50;
  localparam logic [7:0] EE_START_LOC = 8'h00;
  // image line positions
  localparam logic [11:0] LN_CLK = 12'h008;
  localparam logic [11:0] LN_BOOT = 12'h009;
  localparam logic [11:0] LN_CNT = 12'h00a;
  localparam logic [11:0] LN_PAIR_FIRST = 12'h00e;
  localparam logic [11:0] LN_PAIR_LAST = 12'h02a;
  localparam logic [11:0] LN_DEST_END = 12'h02e;
  localparam logic [11:0] LN_PROG = 12'h02f;
  localparam int BOOT_TYPE_BIT = 7;
  // ahb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CLKSET = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0c;
  localparam logic [7:0] REG_DEST = 8'h10;
  localparam logic [7:0] REG_COPIED = 8'h14;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic START_ON_RESET = 1'b1;
  // byte engine commands
  typedef enum logic [2:0] {
    SEL_CMD_START = 3'h0,
    SEL_CMD_STOP = 3'h1,
    SEL_CMD_WRITE = 3'h2,
    SEL_CMD_READ = 3'h3,
    SEL_CMD_ACK = 3'h4
  } sel_cmd_e;
  // loader states, gray coded along the load path
  typedef enum logic [3:0] {
    SEL_IDLE = 4'h0,
    SEL_START = 4'h1,
    SEL_DEVW = 4'h3,
    SEL_LOC = 4'h2,
    SEL_RSTART = 4'h6,
    SEL_DEVR = 4'h7,
    SEL_READ = 4'h5,
    SEL_ACK = 4'h4,
    SEL_STOP = 4'hc
  } sel_state_e;
endpackage
`default_nettype wire

// >>> sel_i2c_engine.sv
// i2c master byte engine: start, stop, byte write, byte read, ack bit
`timescale 1ns/1ps
`default_nettype none
module sel_i2c_engine #(
  parameter int QUARTER = sel_pkg::QUARTER_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cmd_go,
  input wire sel_pkg::sel_cmd_e cmd,
  input wire logic [7:0] cmd_byte,
  output logic done,
  output logic [7:0] rx_byte,
  output logic nack,
  input wire logic scl_i,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_oe
);
  import sel_pkg::*;

  // whole engine state
  typedef struct packed {
    logic busy;
    sel_cmd_e cmd;
    logic [1:0] ph;        // quarter phase within one bit
    logic [3:0] bitn;      // bits finished
    logic [TICK_W-1:0] tick;
    logic [8:0] sh;        // msb drives sda
    logic samp;            // sda sampled while scl high
    logic scl_oe;
    logic sda_oe;
    logic done;
    logic [7:0] rx;
    logic nack;
    logic sda_s1;
    logic sda_s2;
    logic scl_s1;
    logic scl_s2;
  } sel_eng_s;

  sel_eng_s r, next_r;
  logic [8:0] next_sh;
  logic [3:0] nbits;

  // next state of the engine
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.sda_s1 = sda_i;
    next_r.sda_s2 = r.sda_s1;
    next_r.scl_s1 = scl_i;
    next_r.scl_s2 = r.scl_s1;
    next_sh = {r.sh[7:0], r.samp};
    unique case (r.cmd)
      SEL_CMD_WRITE: nbits = 4'd9;
      SEL_CMD_READ: nbits = 4'd8;
      default: nbits = 4'd1;
    endcase
    if (!r.busy) begin
      // accept a command, bus pins hold their last level meanwhile
      if (cmd_go) begin
        next_r.busy = 1'b1;
        next_r.cmd = cmd;
        next_r.ph = 2'd0;
        next_r.bitn = 4'd0;
        next_r.tick = '0;
        if (cmd == SEL_CMD_WRITE) begin
          next_r.sh = {cmd_byte, 1'b1};
        end else if (cmd == SEL_CMD_ACK) begin
          next_r.sh = {cmd_byte[0], 8'hff};
        end else begin
          next_r.sh = 9'h1ff;
        end
      end
    end else begin
      // pin levels per phase
      unique case (r.cmd)
        SEL_CMD_START: begin
          next_r.scl_oe = (r.ph == 2'd0) || (r.ph == 2'd3);
          next_r.sda_oe = r.ph[1];
        end
        SEL_CMD_STOP: begin
          next_r.scl_oe = (r.ph == 2'd0);
          next_r.sda_oe = !r.ph[1];
        end
        default: begin
          next_r.scl_oe = (r.ph == 2'd0) || (r.ph == 2'd3);
          next_r.sda_oe = !r.sh[8];
        end
      endcase
      // wait out a stretched scl in the first high quarter
      if (r.tick == TICK_W'(QUARTER - 1) && !(r.ph == 2'd1 && !r.scl_s2)) begin
        next_r.tick = '0;
        next_r.ph = r.ph + 2'd1;
        if (r.ph == 2'd1) begin
          next_r.samp = r.sda_s2;
        end
        if (r.ph == 2'd3) begin
          next_r.sh = next_sh;
          next_r.bitn = r.bitn + 4'd1;
          if (r.bitn + 4'd1 == nbits) begin
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            next_r.rx = next_sh[7:0];
            next_r.nack = next_sh[0];
          end
        end
      end else if (r.tick != TICK_W'(QUARTER - 1)) begin
        next_r.tick = r.tick + TICK_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{cmd: SEL_CMD_STOP, sh: 9'h1ff, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;
  assign rx_byte = r.rx;
  assign nack = r.nack;
  assign scl_oe = r.scl_oe;
  assign sda_oe = r.sda_oe;
endmodule // sel_i2c_engine
`default_nettype wire

// >>> sel_loader.sv
// boot loader: reads the eeprom image and applies it to the device
`timescale 1ns/1ps
`default_nettype none
module sel_loader #(
  parameter int QUARTER = sel_pkg::QUARTER_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // i2c pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // configuration register writes
  output logic cfg_wr_valid,
  output logic [31:0] cfg_wr_addr,
  output logic [31:0] cfg_wr_data,
  // sdram byte writes
  output logic mem_wr_valid,
  output logic [31:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  // clock control and boot status
  output logic clk_set_valid,
  output logic [7:0] clock_multiplier_settings,
  output logic boot_type_valid,
  output logic boot_type,
  output logic load_done
);
  import sel_pkg::*;

  // whole loader state
  typedef struct packed {
    sel_state_e st;
    logic [11:0] line;        // image line being read
    logic [10:0] count;       // program byte count
    logic [31:0] acc;         // assembles msb first
    logic [31:0] tgt;         // latched register address
    logic [31:0] dest;        // program destination base
    logic last;               // current byte is the final one
    logic go;                 // engine command strobe
    sel_cmd_e cmd;
    logic [7:0] cmd_byte;
    logic start_pend;
    logic nack_err;
    logic done;
    logic btype;
    logic btype_valid;
    logic [7:0] clkset;
    logic clk_valid;
    logic cfg_valid;
    logic [31:0] cfg_addr;
    logic [31:0] cfg_data;
    logic mem_valid;
    logic [31:0] mem_addr;
    logic [7:0] mem_data;
    logic [11:0] copied;
    logic ap_wr;              // pending ahb write data phase
    logic [7:0] ap_addr;
    logic [31:0] rdata;
  } sel_ldr_s;

  sel_ldr_s r, next_r;
  logic eng_done;
  logic [7:0] rx;
  logic eng_nack;
  logic [11:0] j;
  logic [31:0] word_off;

  // register read mux
  function automatic logic [31:0] reg_read(input logic [7:0] a, input sel_ldr_s s);
    logic [31:0] v;
    v = RST_WORD;
    unique case (a)
      REG_STATUS: v = {28'h0, s.btype, s.nack_err, s.done, s.st != SEL_IDLE};
      REG_CLKSET: v = {24'h0, s.clkset};
      REG_COUNT: v = {21'h0, s.count};
      REG_DEST: v = s.dest;
      REG_COPIED: v = {20'h0, s.copied};
      default: v = RST_WORD;
    endcase
    return v;
  endfunction

  // issue one engine command
  function automatic sel_ldr_s issue(input sel_ldr_s s, input sel_cmd_e c, input logic [7:0] b,
                                     input sel_state_e st);
    sel_ldr_s o;
    o = s;
    o.go = 1'b1;
    o.cmd = c;
    o.cmd_byte = b;
    o.st = st;
    return o;
  endfunction

  sel_i2c_engine #(.QUARTER(QUARTER)) u_eng (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .cmd_go(r.go),
    .cmd(r.cmd),
    .cmd_byte(r.cmd_byte),
    .done(eng_done),
    .rx_byte(rx),
    .nack(eng_nack),
    .scl_i(scl_i),
    .scl_oe(scl_oe),
    .sda_i(sda_i),
    .sda_oe(sda_oe)
  );

  // program byte index and its lane-reversed offset
  assign j = r.line - LN_PROG;
  assign word_off = 32'({j[11:2], 2'b00}) + 32'(2'd3 - j[1:0]);

  // next state of loader and bus slave
  always_comb begin
    next_r = r;
    next_r.go = 1'b0;
    next_r.clk_valid = 1'b0;
    next_r.cfg_valid = 1'b0;
    next_r.mem_valid = 1'b0;
    next_r.btype_valid = 1'b0;
    unique case (r.st)
      SEL_IDLE: begin
        // load starts after reset or on software restart
        if (r.start_pend) begin
          next_r = issue(r, SEL_CMD_START, 8'h00, SEL_START);
          next_r.start_pend = 1'b0;
          next_r.line = '0;
          next_r.done = 1'b0;
          next_r.nack_err = 1'b0;
          next_r.copied = '0;
          next_r.count = '0;
        end
      end
      SEL_START: if (eng_done) next_r = issue(r, SEL_CMD_WRITE, {EE_DEV_ADDR, 1'b0}, SEL_DEVW);
      SEL_DEVW: begin
        if (eng_done && eng_nack) begin
          next_r = issue(r, SEL_CMD_STOP, 8'h00, SEL_STOP);
          next_r.nack_err = 1'b1;
        end else if (eng_done) begin
          next_r = issue(r, SEL_CMD_WRITE, EE_START_LOC, SEL_LOC);
        end
      end
      SEL_LOC: begin
        if (eng_done && eng_nack) begin
          next_r = issue(r, SEL_CMD_STOP, 8'h00, SEL_STOP);
          next_r.nack_err = 1'b1;
        end else if (eng_done) begin
          next_r = issue(r, SEL_CMD_START, 8'h00, SEL_RSTART);
        end
      end
      SEL_RSTART: if (eng_done) next_r = issue(r, SEL_CMD_WRITE, {EE_DEV_ADDR, 1'b1}, SEL_DEVR);
      SEL_DEVR: begin
        if (eng_done && eng_nack) begin
          next_r = issue(r, SEL_CMD_STOP, 8'h00, SEL_STOP);
          next_r.nack_err = 1'b1;
        end else if (eng_done) begin
          next_r = issue(r, SEL_CMD_READ, 8'h00, SEL_READ);
        end
      end
      SEL_READ: begin
        if (eng_done) begin
          next_r.last = 1'b0;
          if (r.line == LN_CLK) begin
            next_r.clkset = rx;
            next_r.clk_valid = 1'b1;
          end
          if (r.line == LN_BOOT) begin
            next_r.btype = rx[BOOT_TYPE_BIT];
            next_r.btype_valid = 1'b1;
            next_r.count[10:8] = rx[2:0];
            next_r.last = !rx[BOOT_TYPE_BIT];
          end
          if (r.line == LN_CNT) next_r.count[7:0] = rx;
          if (r.line > LN_CNT && r.line <= LN_DEST_END) next_r.acc = {r.acc[23:0], rx};
          if (r.line >= LN_PAIR_FIRST && r.line[2:0] == 3'd6) next_r.tgt = {r.acc[23:0], rx};
          if (r.line > LN_PAIR_FIRST && r.line <= LN_PAIR_LAST && r.line[2:0] == 3'd2) begin
            next_r.cfg_valid = 1'b1;
            next_r.cfg_addr = r.tgt;
            next_r.cfg_data = {r.acc[23:0], rx};
          end
          if (r.line == LN_DEST_END) next_r.dest = {r.acc[23:0], rx};
          if (r.line >= LN_PROG) begin
            next_r.mem_valid = 1'b1;
            next_r.mem_addr = r.dest + word_off;
            next_r.mem_data = rx;
            next_r.copied = r.copied + 12'd1;
          end
          if (r.line > LN_CNT && r.line == LN_DEST_END + 12'(r.count)) next_r.last = 1'b1;
          next_r = issue(next_r, SEL_CMD_ACK, {7'h0, next_r.last}, SEL_ACK);
        end
      end
      SEL_ACK: begin
        if (eng_done && r.last) begin
          next_r = issue(r, SEL_CMD_STOP, 8'h00, SEL_STOP);
        end else if (eng_done) begin
          next_r = issue(r, SEL_CMD_READ, 8'h00, SEL_READ);
          next_r.line = r.line + 12'd1;
        end
      end
      SEL_STOP: begin
        if (eng_done) begin
          next_r.st = SEL_IDLE;
          next_r.done = !r.nack_err;
        end
      end
      default: next_r.st = SEL_IDLE;
    endcase
    // ahb address phase
    next_r.ap_wr = hsel && htrans[1] && hready && hwrite;
    if (hsel && htrans[1] && hready) begin
      next_r.ap_addr = haddr[7:0];
      next_r.rdata = reg_read(haddr[7:0], r);
    end
    // ahb write data phase: ctrl bit 0 restarts an idle loader
    if (r.ap_wr && r.ap_addr == REG_CTRL && hwdata[0] && r.st == SEL_IDLE) begin
      next_r.start_pend = 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{st: SEL_IDLE, cmd: SEL_CMD_STOP, start_pend: START_ON_RESET, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign cfg_wr_valid = r.cfg_valid;
  assign cfg_wr_addr = r.cfg_addr;
  assign cfg_wr_data = r.cfg_data;
  assign mem_wr_valid = r.mem_valid;
  assign mem_wr_addr = r.mem_addr;
  assign mem_wr_data = r.mem_data;
  assign clk_set_valid = r.clk_valid;
  assign clock_multiplier_settings = r.clkset;
  assign boot_type_valid = r.btype_valid;
  assign boot_type = r.btype;
  assign load_done = r.done;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  logic rd_ok;
  assign rd_ok = r.st == SEL_READ && eng_done;

  sequence dummy_write_s;
    r.st == SEL_START && eng_done ##1 r.go && r.cmd_byte == {EE_DEV_ADDR, 1'b0};
  endsequence

  boot_type_dec_a: assert property (rd_ok && r.line == LN_BOOT |=> boot_type == $past(rx[7]) && boot_type_valid)
    else $error("boot type not taken from bit 7");
  host_no_copy_a: assert property (r.btype_valid && !r.btype |-> ##[1:3] r.last)
    else $error("host boot read past line nine");
  host_quiet_a: assert property (!r.btype && r.line <= LN_BOOT |-> !cfg_wr_valid && !mem_wr_valid)
    else $error("write during host boot lines");
  dram_base_wr_a: assert property (rd_ok && r.line == 12'd26 |=> cfg_wr_valid &&
    cfg_wr_data == {$past(r.acc[23:0]), $past(rx)})
    else $error("sdram base value wrong");
  dram_limit_wr_a: assert property (rd_ok && r.line == 12'd34 |=> cfg_wr_valid && cfg_wr_addr == $past(r.tgt))
    else $error("sdram limit address wrong");
  cache_limit_wr_a: assert property (rd_ok && r.line == 12'd42 |=> cfg_wr_valid ##1 !cfg_wr_valid)
    else $error("cacheable limit write missing");
  dest_base_a: assert property (rd_ok && r.line == LN_DEST_END |=> r.dest == {$past(r.acc[23:0]), $past(rx)})
    else $error("destination base wrong");
  first_byte_a: assert property (rd_ok && r.line == LN_PROG |=> mem_wr_valid && mem_wr_addr == r.dest + 32'd3)
    else $error("first program byte not at base plus 3");
  lane_rev_a: assert property (rd_ok && r.line >= LN_PROG |=> mem_wr_addr[1:0] == 2'd3 - $past(j[1:0]))
    else $error("program byte lane not reversed");
  dev_addr_seq_a: assert property (r.st == SEL_START && eng_done |-> dummy_write_s)
    else $error("dummy write address wrong");
  count_stop_a: assert property (rd_ok && r.btype && r.line == LN_DEST_END + 12'(r.count) |=> r.last)
    else $error("read not ended after count");
  clk_fields_a: assert property (rd_ok && r.line == LN_CLK |=> clk_set_valid &&
    clock_multiplier_settings == $past(rx))
    else $error("clock fields not passed");
endmodule // sel_loader
`default_nettype wire

// >>> sel_loader_sva_placeholder_none.sv
// intentionally empty design unit file holding no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> sel_eeprom_model.sv
// eeprom model: i2c slave that serves a random read and a sequential read
`timescale 1ns/1ps
`default_nettype none
module sel_eeprom_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch,
  input wire logic [6:0] dev,
  output logic scl_pull,
  output logic sda_pull
);
  logic [7:0] mem [256]; // image bytes
  logic [7:0] ptr; // internal address latch
  logic [7:0] loc; // location of the last dummy write
  int nrd; // bytes sent in the last read
  logic [7:0] b; // byte being received
  logic ok; // ack decision or master ack
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    nrd = 0;
  end
  // slow answer: hold the clock low after each fall
  always @(negedge scl) begin
    if (stretch) begin
      scl_pull = 1'b1;
      #200 scl_pull = 1'b0;
    end
  end
  // take a byte, then ack it if wanted
  task automatic rx(input logic chk);
    for (int i = 7; i >= 0; i--) begin
      @(posedge scl);
      b[i] = sda;
    end
    ok = !chk || (b[7:1] == dev);
    @(negedge scl);
    #20 sda_pull = ok;
    @(negedge scl);
    #20 sda_pull = 1'b0;
  endtask
  // send a byte msb first, then read the master's ack
  task automatic tx(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      sda_pull = !d[i];
      @(posedge scl);
      @(negedge scl);
      #20;
    end
    sda_pull = 1'b0;
    @(posedge scl);
    ok = !sda;
    @(negedge scl);
    #20;
  endtask
  initial forever begin
    do @(negedge sda); while (scl !== 1'b1);
    rx(1'b1);
    if (ok) begin
      rx(1'b0);
      loc = b;
      ptr = b;
      nrd = 0;
      do @(negedge sda); while (scl !== 1'b1);
      rx(1'b1);
      while (ok) begin
        tx(mem[ptr]);
        ptr++;
        nrd++;
      end
    end
  end
endmodule // sel_eeprom_model
`default_nettype wire

// >>> sel_loader_test.sv
// testbench for the serial eeprom boot loader
`timescale 1ns/1ps
`default_nettype none
module sel_loader_test;
  import sel_pkg::*;
  localparam int Q = 4; // 160 ns link period
  localparam int NPROG = 8; // program bytes, two words
  localparam logic [31:0] MMIO = 32'h1200_0000;
  localparam logic [31:0] DRAM = 32'h0040_0000;
  localparam logic [31:0] IMG [9] = '{32'hef_f0_04_00, MMIO, MMIO + 32'h10_0000, DRAM,
    MMIO + 32'h10_0004, 32'h0080_0000, MMIO + 32'h10_0008, 32'h0060_0000, DRAM};
  logic ref_clk, reset_n, hsel, hwrite, stretch, bt_seen;
  logic [31:0] haddr, hwdata, hrdata, cfg_wr_addr, cfg_wr_data, mem_wr_addr, first_mem, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] mem_wr_data, clock_multiplier_settings, clk_seen;
  logic [6:0] dev;
  logic hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull;
  logic cfg_wr_valid, mem_wr_valid, clk_set_valid, boot_type_valid, boot_type, load_done;
  logic [63:0] cfg_q [$];
  logic [7:0] sd [logic [31:0]];
  int num_errors = 0;
  int n_tests = 0;
  int nmem = 0;
  // open-drain wires with pull-ups
  wire logic scl = (scl_oe ? scl_o : 1'b1) & ~scl_pull;
  wire logic sda = (sda_oe ? sda_o : 1'b1) & ~sda_pull;
  sel_loader #(.QUARTER(Q)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .cfg_wr_valid(cfg_wr_valid),
    .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data), .mem_wr_valid(mem_wr_valid),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .clk_set_valid(clk_set_valid),
    .clock_multiplier_settings(clock_multiplier_settings), .boot_type_valid(boot_type_valid),
    .boot_type(boot_type), .load_done(load_done));
  sel_eeprom_model uee (.scl(scl), .sda(sda), .stretch(stretch), .dev(dev), .scl_pull(scl_pull),
    .sda_pull(sda_pull));
  // 100 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // record every pulse the loader makes
  always @(posedge ref_clk) begin
    if (cfg_wr_valid === 1'b1) cfg_q.push_back({cfg_wr_addr, cfg_wr_data});
    if (mem_wr_valid === 1'b1) begin
      if (nmem == 0) first_mem = mem_wr_addr;
      sd[mem_wr_addr] = mem_wr_data;
      nmem++;
    end
    if (clk_set_valid === 1'b1) clk_seen = clock_multiplier_settings;
    if (boot_type_valid === 1'b1) bt_seen = boot_type;
  end
  // one ahb-lite single word transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk(v, exp);
    chk(32'(hresp), 32'h0);
  endtask
  // poll status until busy rises and falls again
  task automatic wait_load;
    r = 32'h0;
    for (int i = 0; i < 50 && r[0] !== 1'b1; i++) ahb(1'b0, REG_STATUS, 32'h0, r);
    for (int i = 0; i < 20000 && r[0] !== 1'b0; i++) ahb(1'b0, REG_STATUS, 32'h0, r);
    // a load that never ends counts as a mismatch
    chk(32'(r[0]), 32'h0);
  endtask
  // build the eeprom image
  task automatic load_image(input logic auto_boot);
    for (int i = 0; i < 256; i++) uee.mem[i] = 8'(i) ^ 8'h3c;
    uee.mem[8] = 8'h5a;
    uee.mem[9] = {auto_boot, 7'h00};
    uee.mem[10] = 8'(NPROG);
    for (int k = 0; k < 36; k++) uee.mem[11 + k] = 8'(IMG[k / 4] >> (8 * (3 - k % 4)));
    for (int j = 0; j < NPROG; j++) uee.mem[47 + j] = 8'h10 + 8'(j);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog well above three loads
  initial begin
    #500000;
    num_errors++;
    end_of_test;
  end
  initial begin
    {reset_n, hsel, hwrite, stretch} = 4'h0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'b010;
    dev = 7'h50;
    load_image(1'b1);
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    // autonomous load straight after reset
    wait_load;
    chk(32'(clk_seen), 32'h5a);
    chk(32'(bt_seen), 32'h1);
    chk(32'(cfg_q.size()), 32'h4);
    for (int k = 0; k < 4; k++) chk(cfg_q[k][63:32], IMG[2 * k]);
    for (int k = 0; k < 4; k++) chk(cfg_q[k][31:0], IMG[2 * k + 1]);
    chk(32'(nmem), NPROG);
    chk(first_mem, DRAM + 32'h3);
    for (int j = 0; j < NPROG; j++) chk(32'(sd[DRAM + 32'(4 * (j / 4) + 3 - j % 4)]), 32'h10 + 32'(j));
    chk(32'(uee.loc), 32'h0);
    chk(32'(uee.nrd), 32'(47 + NPROG));
    chk(32'(load_done), 32'h1);
    rdchk(REG_STATUS, 32'h0000_000a);
    rdchk(REG_CLKSET, 32'h5a);
    rdchk(REG_COUNT, NPROG);
    rdchk(REG_DEST, DRAM);
    rdchk(REG_COPIED, NPROG);
    rdchk(8'h20, 32'h0);
    $display("test autonomous done");
    // host boot restart, eeprom stretching the clock
    load_image(1'b0);
    stretch <= 1'b1;
    cfg_q.delete();
    nmem = 0;
    bt_seen = 1'b1;
    ahb(1'b1, REG_CTRL, 32'h1, r);
    wait_load;
    chk(32'(bt_seen), 32'h0);
    chk(32'(cfg_q.size()) | 32'(nmem), 32'h0);
    chk(32'(uee.nrd), 32'd10);
    rdchk(REG_STATUS, 32'h0000_0002);
    $display("test host done");
    // eeprom answers to another address
    stretch <= 1'b0;
    dev <= 7'h51;
    ahb(1'b1, REG_CTRL, 32'h1, r);
    wait_load;
    chk(r & 32'h7, 32'h4);
    chk(32'(load_done), 32'h0);
    $display("test nack done");
    end_of_test;
  end
endmodule // sel_loader_test
`default_nettype wire
